// ==== hw/ebcs_bus_map.vh ====
// How it works
// - address outputs held from strobe until cycle ends
// - address strobe only with valid cycle definition
// - byte enables encode word, upper, lower, refresh
// - data bus input on reads, output writes
// - read data captured end of second state
// - write data driven first-state phase two onward
// - local access asserted for internal termination
// - lock output keeps cycle sequence indivisible
// - status pins encode the cycle type
// - halt/shutdown use byte address two/zero
// - read strobe only in read cycles
// - write strobe only while driving write data
// - ready pin driven locally, else sampled
`ifndef EBCS_BUS_MAP_VH
`define EBCS_BUS_MAP_VH

// bus states
`define EBCS_ST_IDLE 2'h0
`define EBCS_ST_T1 2'h1
`define EBCS_ST_T2 2'h2

// request cycle types
`define EBCS_CY_INTACK 4'h0
`define EBCS_CY_IO_RD 4'h1
`define EBCS_CY_IO_WR 4'h2
`define EBCS_CY_CODE_RD 4'h3
`define EBCS_CY_HALT 4'h4
`define EBCS_CY_SHUTDOWN 4'h5
`define EBCS_CY_REFRESH 4'h6
`define EBCS_CY_MEM_RD 4'h7
`define EBCS_CY_MEM_WR 4'h8

// status pin codes {mem_io, data_ctrl, write_read}
`define EBCS_ST_CODE_INTACK 3'h0
`define EBCS_ST_CODE_IO_RD 3'h2
`define EBCS_ST_CODE_IO_WR 3'h3
`define EBCS_ST_CODE_CODE_RD 3'h4
`define EBCS_ST_CODE_HALT 3'h5
`define EBCS_ST_CODE_MEM_RD 3'h6
`define EBCS_ST_CODE_MEM_WR 3'h7

// word address for halt (byte address two) and shutdown (zero)
`define EBCS_HALT_WORD_ADDR 25'h0000001
`define EBCS_SHUTDOWN_WORD_ADDR 25'h0000000

`endif

// ==== hw/ebcs_bus_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ebcs_bus_map.vh"

module ebcs_bus_unit #(
    parameter WAIT_W = 4
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // user request side
    input wire req_valid,
    input wire [3:0] req_type,
    input wire [25:0] req_addr,
    input wire req_word,
    input wire [15:0] req_wdata,
    input wire req_lock,
    input wire req_local,
    input wire [WAIT_W-1:0] req_local_waits,
    output reg req_taken,
    output reg cycle_done,
    output reg [15:0] rd_data,
    output reg narrow_seen,
    // address and status pins
    output reg addr_strobe_n,
    output reg [24:0] word_addr_out,
    output reg upper_byte_en_n,
    output reg lower_byte_en_n,
    output reg mem_io,
    output reg data_ctrl,
    output reg write_read,
    output reg refresh_n,
    output reg lock_n,
    output reg local_access_n,
    output reg rd_n,
    output reg wr_n,
    // data bus pins
    input wire [15:0] data_bus_in,
    output reg [15:0] data_bus_out,
    output reg data_bus_oe_n,
    // ready pin and bus size input
    input wire ready_in,
    output reg ready_out,
    output reg ready_oe_n,
    input wire narrow_port_n
);

////////////////////////////////////////////////////////////////////////////////
reg [1:0] state_reg;
reg phase_reg;
reg [3:0] type_reg;
reg word_reg;
reg second_reg;
reg local_reg;
reg [WAIT_W-1:0] wait_reg;
reg [15:0] wdata_reg;

wire is_write = (type_reg == `EBCS_CY_IO_WR) || (type_reg == `EBCS_CY_MEM_WR);
wire is_read = (type_reg == `EBCS_CY_IO_RD) || (type_reg == `EBCS_CY_MEM_RD) ||
               (type_reg == `EBCS_CY_CODE_RD) || (type_reg == `EBCS_CY_INTACK);
wire is_data = is_write || (is_read && type_reg != `EBCS_CY_INTACK);
wire t2_end = (state_reg == `EBCS_ST_T2) && phase_reg;
// local cycles end on the wait count, external ones on the sampled ready pin
wire term = t2_end && (local_reg ? (wait_reg == {WAIT_W{1'b0}}) : ~ready_in);
// a word to an eight-bit port needs a second cycle for the upper byte
wire split = term && word_reg && ~second_reg && is_data && ~narrow_port_n;
wire bound = phase_reg && ((state_reg == `EBCS_ST_IDLE) || (term && ~split));
wire accept = bound && req_valid;

reg [2:0] code_c;
always @* begin
    case (req_type)
        `EBCS_CY_INTACK: code_c = `EBCS_ST_CODE_INTACK;
        `EBCS_CY_IO_RD: code_c = `EBCS_ST_CODE_IO_RD;
        `EBCS_CY_IO_WR: code_c = `EBCS_ST_CODE_IO_WR;
        `EBCS_CY_CODE_RD: code_c = `EBCS_ST_CODE_CODE_RD;
        `EBCS_CY_HALT: code_c = `EBCS_ST_CODE_HALT;
        `EBCS_CY_SHUTDOWN: code_c = `EBCS_ST_CODE_HALT;
        `EBCS_CY_REFRESH: code_c = `EBCS_ST_CODE_MEM_RD;
        `EBCS_CY_MEM_RD: code_c = `EBCS_ST_CODE_MEM_RD;
        `EBCS_CY_MEM_WR: code_c = `EBCS_ST_CODE_MEM_WR;
        default: code_c = `EBCS_ST_CODE_MEM_RD;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk) begin
    if (!reset_n) begin
        state_reg <= `EBCS_ST_IDLE;
        phase_reg <= 1'b0;
        type_reg <= `EBCS_CY_MEM_RD;
        word_reg <= 1'b0;
        second_reg <= 1'b0;
        local_reg <= 1'b0;
        wait_reg <= {WAIT_W{1'b0}};
        wdata_reg <= 16'h0000;
        req_taken <= 1'b0;
        cycle_done <= 1'b0;
        rd_data <= 16'h0000;
        narrow_seen <= 1'b0;
        addr_strobe_n <= 1'b1;
        word_addr_out <= 25'h0000000;
        upper_byte_en_n <= 1'b1;
        lower_byte_en_n <= 1'b1;
        mem_io <= 1'b0;
        data_ctrl <= 1'b0;
        write_read <= 1'b0;
        refresh_n <= 1'b1;
        lock_n <= 1'b1;
        local_access_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        data_bus_out <= 16'h0000;
        data_bus_oe_n <= 1'b1;
        ready_out <= 1'b1;
        ready_oe_n <= 1'b1;
    end else begin
        phase_reg <= ~phase_reg;
        req_taken <= accept;
        cycle_done <= 1'b0;

        // T1 phase one ends: strobe stays low, write data and write strobe start in phase two
        if (state_reg == `EBCS_ST_T1 && !phase_reg) begin
            data_bus_oe_n <= ~is_write;
            data_bus_out <= wdata_reg;
            wr_n <= ~is_write;
        end
        // idle phase one ends: write data released one phase after the cycle
        if (state_reg == `EBCS_ST_IDLE && !phase_reg)
            data_bus_oe_n <= 1'b1;

        // T1 ends: enter T2, strobe off, read strobe on
        if (state_reg == `EBCS_ST_T1 && phase_reg) begin
            state_reg <= `EBCS_ST_T2;
            addr_strobe_n <= 1'b1;
            rd_n <= ~is_read;
            ready_out <= ~(local_reg && wait_reg == {WAIT_W{1'b0}});
        end

        // T2 ends: sample data and ready, or insert a wait state
        if (t2_end) begin
            if (!term) begin
                if (local_reg) begin
                    wait_reg <= wait_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
                    ready_out <= ~(wait_reg == {{(WAIT_W-1){1'b0}}, 1'b1});
                end
            end else begin
                rd_n <= 1'b1;
                wr_n <= 1'b1;
                ready_out <= 1'b1;
                ready_oe_n <= 1'b1;
                local_access_n <= 1'b1;
                if (is_read) begin
                    // narrow ports return each byte on the low lane
                    if (second_reg)
                        rd_data[15:8] <= data_bus_in[7:0];
                    else if (split)
                        rd_data[7:0] <= data_bus_in[7:0];
                    else
                        rd_data <= data_bus_in;
                end
                if (split) begin
                    state_reg <= `EBCS_ST_T1;
                    second_reg <= 1'b1;
                    addr_strobe_n <= 1'b0;
                    upper_byte_en_n <= 1'b0;
                    lower_byte_en_n <= 1'b1;
                    wdata_reg <= {wdata_reg[15:8], wdata_reg[15:8]};
                    local_access_n <= ~local_reg;
                    ready_oe_n <= ~local_reg;
                end else begin
                    cycle_done <= 1'b1;
                    narrow_seen <= second_reg;
                    state_reg <= `EBCS_ST_IDLE;
                    // lock only survives into a back-to-back locked cycle
                    if (!accept)
                        lock_n <= 1'b1;
                end
            end
        end

        // start a new cycle on a bus-state boundary
        if (accept) begin
            state_reg <= `EBCS_ST_T1;
            type_reg <= req_type;
            word_reg <= req_word;
            second_reg <= 1'b0;
            local_reg <= req_local;
            wait_reg <= req_local_waits;
            wdata_reg <= req_wdata;
            addr_strobe_n <= 1'b0;
            {mem_io, data_ctrl, write_read} <= code_c;
            refresh_n <= ~(req_type == `EBCS_CY_REFRESH);
            lock_n <= ~req_lock;
            local_access_n <= ~req_local;
            ready_oe_n <= ~req_local;
            // address stays until the next cycle starts
            if (req_type == `EBCS_CY_HALT) begin
                word_addr_out <= `EBCS_HALT_WORD_ADDR;
                upper_byte_en_n <= 1'b1;
                lower_byte_en_n <= 1'b0;
            end else if (req_type == `EBCS_CY_SHUTDOWN) begin
                word_addr_out <= `EBCS_SHUTDOWN_WORD_ADDR;
                upper_byte_en_n <= 1'b1;
                lower_byte_en_n <= 1'b0;
            end else begin
                word_addr_out <= req_addr[25:1];
                if (req_type == `EBCS_CY_REFRESH) begin
                    upper_byte_en_n <= 1'b1;
                    lower_byte_en_n <= 1'b1;
                end else if (req_word) begin
                    upper_byte_en_n <= 1'b0;
                    lower_byte_en_n <= 1'b0;
                end else begin
                    upper_byte_en_n <= ~req_addr[0];
                    lower_byte_en_n <= req_addr[0];
                end
            end
        end
    end
end

endmodule // ebcs_bus_unit
`default_nettype wire

// ==== sim/ebcs_bus_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebcs_bus_partner (
    // clock and bench controls
    input wire logic core_clk,
    input wire logic [3:0] waits,
    input wire logic narrow8,
    // device pins
    input wire logic addr_strobe_n,
    input wire logic [24:0] word_addr_out,
    input wire logic upper_byte_en_n,
    input wire logic lower_byte_en_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] data_bus_out,
    input wire logic data_bus_oe_n,
    input wire logic ready_out,
    input wire logic ready_oe_n,
    // far-side pins
    output logic [15:0] data_bus_in,
    output logic ready_in,
    output logic narrow_port_n
);
    logic [15:0] mem [0:15];
    logic [15:0] w;
    logic [4:0] cnt;
    assign w = mem[word_addr_out[3:0]];
    // never takes the bus and never asks for an early address
    assign narrow_port_n = !narrow8;
    assign ready_in = !ready_oe_n ? ready_out : (cnt < 2 * waits);
    // a released bus shows the inverse, so a stale copy cannot pass
    assign data_bus_in = !data_bus_oe_n ? data_bus_out : rd_n ? ~data_bus_out :
        (narrow8 && lower_byte_en_n) ? {8'h00, w[15:8]} : w;
    always @(posedge core_clk) begin
        cnt <= addr_strobe_n ? cnt + 5'h01 : 5'h00;
        if (!wr_n && !ready_in && addr_strobe_n) begin
            if (!lower_byte_en_n) mem[word_addr_out[3:0]][7:0] <= data_bus_out[7:0];
            if (!upper_byte_en_n) mem[word_addr_out[3:0]][15:8] <= data_bus_out[15:8];
        end
    end
endmodule // ebcs_bus_partner
`default_nettype wire

// ==== sim/ebcs_bus_unit_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebcs_bus_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // pins watched
    input wire logic addr_strobe_n,
    input wire logic [24:0] word_addr_out,
    input wire logic upper_byte_en_n,
    input wire logic lower_byte_en_n,
    input wire logic mem_io,
    input wire logic data_ctrl,
    input wire logic write_read,
    input wire logic refresh_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic data_bus_oe_n,
    input wire logic ready_oe_n,
    input wire logic local_access_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    addr_hold_a: assert property ($changed(word_addr_out) |-> $fell(addr_strobe_n))
        else $error("word address moved mid cycle");
    strobe_len_a: assert property ($fell(addr_strobe_n) |=> !addr_strobe_n ##1 addr_strobe_n)
        else $error("address strobe length wrong");
    status_legal_a: assert property (!addr_strobe_n |-> mem_io || data_ctrl || !write_read)
        else $error("unused status code");
    refresh_en_a: assert property (!addr_strobe_n |-> !refresh_n == (upper_byte_en_n && lower_byte_en_n))
        else $error("refresh enables wrong");
    halt_addr_a: assert property (!addr_strobe_n && mem_io && !data_ctrl && write_read |->
        upper_byte_en_n && !lower_byte_en_n && word_addr_out[24:1] == 24'h000000)
        else $error("halt address or enables wrong");
    read_dir_a: assert property (!rd_n |-> data_bus_oe_n && !write_read)
        else $error("read strobe with driven bus");
    write_data_a: assert property (!wr_n |-> !data_bus_oe_n && write_read)
        else $error("write strobe without data");
    wr_start_a: assert property ($fell(addr_strobe_n) && write_read && data_ctrl |=> !data_bus_oe_n && !wr_n)
        else $error("write data late");
    local_ready_a: assert property (!ready_oe_n |-> !local_access_n)
        else $error("ready driven outside local cycle");
    local_start_a: assert property ($fell(local_access_n) |-> $fell(addr_strobe_n))
        else $error("local access off cycle start");
    cover property ($fell(wr_n));
    cover property ($fell(rd_n));
    cover property ($fell(ready_oe_n));
endmodule // ebcs_bus_checker
bind ebcs_bus_unit ebcs_bus_checker i_ebcs_bus_checker (.core_clk, .reset_n, .addr_strobe_n, .word_addr_out,
    .upper_byte_en_n, .lower_byte_en_n, .mem_io, .data_ctrl, .write_read, .refresh_n, .rd_n, .wr_n,
    .data_bus_oe_n, .ready_oe_n, .local_access_n);
`default_nettype wire

// ==== sim/external_bus_cycle_signaling_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_signaling_tb;
    logic core_clk, reset_n, req_valid, req_word, req_lock, req_local, req_taken, cycle_done, narrow_seen;
    logic [3:0] req_type, req_local_waits, pw;
    logic [25:0] req_addr;
    logic [15:0] req_wdata, rd_data, data_bus_in, data_bus_out;
    logic [24:0] word_addr_out, sa;
    logic addr_strobe_n, upper_byte_en_n, lower_byte_en_n, mem_io, data_ctrl, write_read, refresh_n, lock_n;
    logic local_access_n, rd_n, wr_n, data_bus_oe_n, ready_in, ready_out, ready_oe_n, narrow_port_n, nar8;
    logic [5:0] st;
    logic lk, lo;
    int mismatches, check_count;
    localparam logic [5:0] type_code [0:8] = '{6'h04, 6'h14, 6'h1C, 6'h24, 6'h2E, 6'h2E, 6'h33, 6'h34, 6'h3C};
    ebcs_bus_unit i_ebcs_bus_unit (.core_clk, .reset_n, .req_valid, .req_type, .req_addr, .req_word, .req_wdata,
        .req_lock, .req_local, .req_local_waits, .req_taken, .cycle_done, .rd_data, .narrow_seen, .addr_strobe_n,
        .word_addr_out, .upper_byte_en_n, .lower_byte_en_n, .mem_io, .data_ctrl, .write_read, .refresh_n, .lock_n,
        .local_access_n, .rd_n, .wr_n, .data_bus_in, .data_bus_out, .data_bus_oe_n, .ready_in, .ready_out,
        .ready_oe_n, .narrow_port_n);
    ebcs_bus_partner i_ebcs_bus_partner (.core_clk, .waits(pw), .narrow8(nar8), .addr_strobe_n, .word_addr_out,
        .upper_byte_en_n, .lower_byte_en_n, .rd_n, .wr_n, .data_bus_out, .data_bus_oe_n, .ready_out, .ready_oe_n,
        .data_bus_in, .ready_in, .narrow_port_n);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input [24:0] e, input [24:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request, held until taken; status is caught while the strobe is low
    task automatic op(input [3:0] t, input [25:0] a, input [15:0] d, input l);
        req_type <= t; req_addr <= a; req_wdata <= d; req_local <= l; req_valid <= 1'b1;
        lo = 1'b0;
        for (int n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (req_taken === 1'b1) req_valid <= 1'b0;
            if (addr_strobe_n === 1'b0) begin
                st = {mem_io, data_ctrl, write_read, refresh_n, upper_byte_en_n, lower_byte_en_n};
                sa = word_addr_out;
                lk = lock_n;
            end
            if (local_access_n === 1'b0) lo = 1'b1;
            if (cycle_done === 1'b1) break;
        end
        chk("cycle done", 25'h1, {24'h0, cycle_done});
    endtask
    task automatic t_types;
        for (int t = 0; t < 9; t++) begin
            op(t[3:0], 26'h40, 16'h0000, 1'b0);
            chk("status", {19'h0, type_code[t]}, {19'h0, st});
            if (t == 4 || t == 5) chk("halt addr", (t == 4) ? 25'h1 : 25'h0, sa);
        end
        $display("types done");
    endtask
    task automatic t_rw;
        pw <= 4'h2;
        op(4'h8, 26'h10, 16'hA5C3, 1'b0);
        req_word <= 1'b0;
        op(4'h8, 26'h11, 16'h7E7E, 1'b0);
        req_word <= 1'b1;
        op(4'h7, 26'h10, 16'h0000, 1'b0);
        chk("read word", 25'h7EC3, {9'h0, rd_data});
        $display("read write done");
    endtask
    task automatic t_narrow;
        nar8 <= 1'b1;
        op(4'h8, 26'h20, 16'h1234, 1'b0);
        op(4'h7, 26'h20, 16'h0000, 1'b0);
        chk("narrow read", 25'h1234, {9'h0, rd_data});
        chk("narrow seen", 25'h1, {24'h0, narrow_seen});
        nar8 <= 1'b0;
        $display("narrow done");
    endtask
    task automatic t_local;
        req_lock <= 1'b1;
        op(4'h7, 26'h10, 16'h0000, 1'b1);
        chk("local access", 25'h1, {24'h0, lo});
        chk("lock", 25'h0, {24'h0, lk});
        chk("lock release", 25'h1, {24'h0, lock_n});
        chk("local read", 25'h7EC3, {9'h0, rd_data});
        req_lock <= 1'b0;
        $display("local done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0; req_valid = 1'b0; req_word = 1'b1; req_lock = 1'b0; req_local = 1'b0; pw = 4'h0;
        req_type = 4'h0; req_addr = 26'h0; req_wdata = 16'h0; req_local_waits = 4'h2; nar8 = 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_types;
        t_rw;
        t_narrow;
        t_local;
        final_report;
    end
    initial begin
        #100000;
        mismatches++;
        final_report;
    end
endmodule // external_bus_cycle_signaling_tb
`default_nettype wire
